// ==== common/mcgw_pkg.sv ====
/*
  Shared constants and types for the machine-check global control and
  instruction watchdog block: register addresses, field positions,
  tick-base and period encodings, and the request and state carriers.
  Assumes a single 25 MHz core clock.
*/
package mcgw_pkg;

  // Register access word
  localparam int MSR_ADDR_W = 32;
  localparam int MSR_DATA_W = 64;

  // Register addresses (mcgw_top decodes them for the core's register accesses)
  localparam logic [31:0] ADDR_CAPABILITIES = 32'h0000_0100;
  localparam logic [31:0] ADDR_GLOBAL_STATE = 32'h0000_0101;
  localparam logic [31:0] ADDR_BANK_ENABLES = 32'h0000_0102;
  localparam logic [31:0] ADDR_WDOG_CONFIG  = 32'h0000_0103;

  // Capability fields
  localparam int CAP_BANK_COUNT_W    = 8;
  localparam int CAP_CTL_PRESENT_BIT = 8;

  // Implementation defaults
  localparam int DEF_BANK_COUNT = 4;
  localparam bit DEF_CTL_PRESENT = 1'b1;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_MS_NS    = 1000000;
  localparam int TICK_US_NS    = 1000;
  localparam int TICK_FAST_NS  = 5;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int TICK_MS_CYCLES   = ns_to_cycles(TICK_MS_NS);
  localparam int TICK_US_CYCLES   = ns_to_cycles(TICK_US_NS);
  localparam int TICK_FAST_CYCLES = ns_to_cycles(TICK_FAST_NS);
  localparam int PRESCALE_W       = 16;

  // Tick base encodings; 2'h3 is reserved
  localparam logic [1:0] TICK_SEL_MS   = 2'h0;
  localparam logic [1:0] TICK_SEL_US   = 2'h1;
  localparam logic [1:0] TICK_SEL_FAST = 2'h2;

  // Period field decode; codes above PERIOD_LAST_SEL are reserved
  localparam int         PERIOD_W        = 14;
  localparam logic [3:0] PERIOD_LAST_SEL = 4'h9;
  localparam logic [13:0] PERIOD_TABLE [10] = '{
    14'h0FFF, 14'h07FF, 14'h03FF, 14'h01FF, 14'h00FF,
    14'h007F, 14'h003F, 14'h001F, 14'h1FFF, 14'h3FFF
  };

  // Watchdog configuration, bit 0 upward: enable, tick base, period
  typedef struct packed {
    logic [3:0] period_sel;
    logic [1:0] tick_base_select;
    logic       enable;
  } mcgw_wdog_cfg_s;
  localparam int WD_CFG_W = $bits(mcgw_wdog_cfg_s);

  // Global state, bit 2 downward
  typedef struct packed {
    logic check_in_progress;
    logic error_pointer_valid;
    logic restart_pointer_valid;
  } mcgw_global_state_s;
  localparam int GS_W = $bits(mcgw_global_state_s);

  // One register access from the core
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [63:0] wdata;
  } mcgw_msr_req_s;

  typedef enum logic [0:0] {
    CORE_RUN,
    CORE_SHUTDOWN
  } mcgw_core_state_e;

endpackage

// ==== verification/mcgw_core_model.sv ====
/*
  Behavioural core pipeline seen by the watchdog: retires one
  instruction every retire_gap_in cycles and enters halt on request.
  Assumes the bench drives its controls just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mcgw_core_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // Controls from the bench
  input  wire logic [7:0] retire_gap_in,
  input  wire logic       halt_req_in,
  // Pipeline status
  output logic            retire_out,
  output logic            halt_out
);
  logic [7:0] count;
  // A halted core retires nothing, so halt also stops completions
  wire logic run_retire = (retire_gap_in != 8'h00) && !halt_req_in;
  wire logic gap_done   = (count + 8'h01) >= retire_gap_in;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count      <= 8'h00;
      retire_out <= 1'b0;
      halt_out   <= 1'b0;
    end else begin
      halt_out   <= halt_req_in;
      retire_out <= run_retire && gap_done;
      count      <= (!run_retire || gap_done) ? 8'h00 : count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_machine_check_global_watchdog.sv ====
/*
  Self-checking bench for the machine-check global control block:
  register access, trap and shutdown, and watchdog timing.
  Assumes the short millisecond base set by MSC below.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_machine_check_global_watchdog;
  localparam int NB  = 4;
  localparam int MSC = 50;
  localparam logic [31:0] CAP = mcgw_pkg::ADDR_CAPABILITIES;
  localparam logic [31:0] GS  = mcgw_pkg::ADDR_GLOBAL_STATE;
  localparam logic [31:0] BE  = mcgw_pkg::ADDR_BANK_ENABLES;
  localparam logic [31:0] WD  = mcgw_pkg::ADDR_WDOG_CONFIG;

  logic clk_in, reset_n_in, warm, err, ok, ip, ack, fault, trap, shut;
  logic retire, halt, halt_req;
  logic [1:0]    bank;
  logic [NB-1:0] always_log, log_en;
  logic [63:0]   rdata, rd;
  logic [7:0]    gap;
  logic [3:0]    p;
  logic [1:0]    b;
  logic          f;
  mcgw_pkg::mcgw_msr_req_s req;
  int miscompares = 0;
  int compares = 0;
  int n, tk, ex;
  int per [10] = '{4095, 2047, 1023, 511, 255, 127, 63, 31, 8191, 16383};

  mcgw_top #(.BANK_COUNT(NB), .CTL_PRESENT(1'b1), .MS_CYCLES(MSC)) DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
    .warm_reset_in(warm), .msr_req_in(req), .msr_ack_out(ack),
    .msr_fault_out(fault), .msr_rdata_out(rdata),
    .insn_retire_in(retire), .halt_in(halt), .mc_error_in(err),
    .mc_error_bank_in(bank), .mc_restart_ok_in(ok), .mc_error_ip_in(ip),
    .always_log_in(always_log), .bank_log_en_out(log_en),
    .hardware_fault_trap_out(trap), .shutdown_out(shut));

  mcgw_core_model core (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .retire_gap_in(gap), .halt_req_in(halt_req),
    .retire_out(retire), .halt_out(halt));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic step;
    @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input string name, input logic [63:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request stands one cycle; ack and data are taken at the next edge
  task automatic acc(input logic r, w, input logic [31:0] a,
                     input logic [63:0] d);
    step;
    req.rd = r;
    req.wr = w;
    req.addr = a;
    req.wdata = d;
    step;
    chk("ack", {63'h0, ack}, 64'h1);
    rd = rdata;
    f = fault;
    req = '0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [63:0] d);
    acc(1'b0, 1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [63:0] e);
    acc(1'b1, 1'b0, a, 64'h0);
    chk("rdata", rd, e);
  endtask

  task automatic mc(input logic [1:0] bk, input logic o, i);
    step;
    err = 1'b1;
    bank = bk;
    ok = o;
    ip = i;
    step;
    err = 1'b0;
  endtask

  task automatic wait_trap(input int lim);
    n = 0;
    while (trap !== 1'b1 && n < lim) begin
      step;
      n++;
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    miscompares++;
    report_and_stop;
  end

  initial begin
    {reset_n_in, warm, err, ok, ip, halt_req} = '0;
    bank = '0;
    always_log = '0;
    gap = '0;
    req = '0;
    repeat (2) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    rdc(CAP, 64'h104);
    wr(CAP, '1);
    rdc(CAP, 64'h104);
    acc(1'b1, 1'b0, 32'h0000_0200, 64'h0);
    chk("fault", {63'h0, f}, 64'h1);
    rdc(GS, 64'h0);
    rdc(WD, 64'h0);
    wr(BE, '1);
    step;
    chk("log_en", {60'h0, log_en}, 64'hF);
    mc(2'h0, 1'b1, 1'b0);
    chk("trap", {63'h0, trap}, 64'h1);
    step;
    chk("trap_end", {63'h0, trap}, 64'h0);
    rdc(GS, 64'h5);
    wr(GS, 64'h0);
    mc(2'h1, 1'b0, 1'b1);
    rdc(GS, 64'h6);
    mc(2'h2, 1'b1, 1'b1);
    chk("no_trap", {63'h0, trap}, 64'h0);
    chk("shut", {63'h0, shut}, 64'h1);
    step;
    warm = 1'b1;
    step;
    warm = 1'b0;
    chk("shut_clr", {63'h0, shut}, 64'h0);
    rdc(GS, 64'h6);
    chk("log_keep", {60'h0, log_en}, 64'hF);
    wr(GS, 64'h0);
    wr(BE, 64'h0);
    always_log = 4'b0010;
    step;
    step;
    chk("log_dis", {60'h0, log_en}, 64'h2);
    mc(2'h0, 1'b1, 1'b0);
    chk("dis_trap", {63'h0, trap}, 64'h0);
    wr(BE, '1);
    // Ten period codes on the fast base, then slower bases on code 7
    for (int i = 0; i < 12; i++) begin
      b = (i < 10) ? 2'h2 : ((i == 10) ? 2'h1 : 2'h0);
      p = (i < 10) ? 4'(i) : 4'h7;
      tk = (b == 2'h2) ? 1 : ((b == 2'h1) ? 25 : MSC);
      ex = per[p] * tk;
      wr(WD, {57'h0, p, b, 1'b1});
      wait_trap(ex + tk + 10);
      chk("expiry", 64'(n >= ex - 2 && n <= ex + tk + 2), 64'h1);
      wr(WD, 64'h0);
      rdc(GS, 64'h4);
      wr(GS, 64'h0);
    end
    wr(WD, {57'h0, 4'h7, 2'h2, 1'b0});
    wait_trap(100);
    chk("off", 64'(n), 64'd100);
    wr(WD, {57'h0, 4'h7, 2'h3, 1'b1});
    wait_trap(400);
    chk("rsv_base", 64'(n), 64'd400);
    wr(WD, {57'h0, 4'hA, 2'h2, 1'b1});
    wait_trap(400);
    chk("rsv_per", 64'(n), 64'd400);
    gap = 8'd20;
    wr(WD, {57'h0, 4'h7, 2'h2, 1'b1});
    wait_trap(200);
    chk("retire", 64'(n), 64'd200);
    gap = 8'd0;
    wr(WD, 64'h0);
    wr(WD, {57'h0, 4'h7, 2'h2, 1'b1});
    repeat (15) step;
    halt_req = 1'b1;
    wait_trap(100);
    chk("halt", 64'(n), 64'd100);
    halt_req = 1'b0;
    wait_trap(40);
    chk("resume", 64'(n >= 11 && n <= 19), 64'h1);
    wr(WD, 64'h0);
    wr(GS, 64'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire

// ==== verilog/mcgw_period_counter.sv ====
/*
  Watchdog period counter: counts ticks and pulses expiry once the
  selected period has elapsed. Assumes ticks from the prescaler.
*/
`timescale 1ns/1ps
`default_nettype none
module mcgw_period_counter #(
  parameter int W = mcgw_pkg::PERIOD_W
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic       hold_in,
  input  wire logic       tick_in,
  input  wire logic [3:0] period_sel_in,
  // Expiry strobe
  output logic            expire_out
);

  logic [W-1:0] cnt;
  logic [W-1:0] limit;
  logic         sel_ok;

  assign sel_ok = (period_sel_in <= mcgw_pkg::PERIOD_LAST_SEL); // RULE_19
  assign limit  = sel_ok ? W'(mcgw_pkg::PERIOD_TABLE[period_sel_in])
                         : '0; // RULE_16
  // Period is the selected count of ticks
  assign expire_out = ce_in && tick_in && sel_ok && !clear_in
                      && (cnt == limit - W'(1)); // RULE_15

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt <= '0;
    end else if (ce_in) begin
      if (clear_in || expire_out) begin
        cnt <= '0; // RULE_18
      end else if (tick_in && !hold_in) begin
        cnt <= cnt + W'(1);
      end
    end
  end

  halt_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && hold_in && !clear_in |=> $stable(cnt))
    else $error("count moved while halted"); // RULE_12
  clear_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ce_in && clear_in |=> cnt == '0)
    else $error("count not restarted"); // RULE_11
  reserved_sel_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !sel_ok |-> !expire_out) else $error("expiry on reserved period"); // RULE_19

endmodule
`default_nettype wire

// ==== verilog/mcgw_tick_gen.sv ====
/*
  Watchdog tick prescaler: one tick pulse per selected time base.
  Assumes clear, run and select come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mcgw_tick_gen #(
  parameter int MS_CYCLES   = mcgw_pkg::TICK_MS_CYCLES,
  parameter int US_CYCLES   = mcgw_pkg::TICK_US_CYCLES,
  parameter int FAST_CYCLES = mcgw_pkg::TICK_FAST_CYCLES,
  parameter int W           = mcgw_pkg::PRESCALE_W
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  // Control
  input  wire logic       clear_in,
  input  wire logic       run_in,
  input  wire logic [1:0] base_sel_in,
  // Tick strobe
  output logic            tick_out
);

  logic [W-1:0] div;
  logic [W-1:0] div_last;
  logic         base_ok;

  assign div_last = (base_sel_in == mcgw_pkg::TICK_SEL_MS) ? W'(MS_CYCLES - 1) :
                    (base_sel_in == mcgw_pkg::TICK_SEL_US) ? W'(US_CYCLES - 1) :
                    W'(FAST_CYCLES - 1); // RULE_14
  assign base_ok  = (base_sel_in != 2'h3); // RULE_19
  assign tick_out = ce_in && run_in && !clear_in && base_ok
                    && (div == div_last);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div <= '0;
    end else if (ce_in) begin
      if (clear_in || tick_out) begin
        div <= '0;
      end else if (run_in && base_ok) begin
        div <= div + W'(1);
      end
    end
  end

  // Reserved tick base: never produces a tick
  reserved_base_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (base_sel_in == 2'h3) |-> !tick_out) else $error("tick on reserved base"); // RULE_19

endmodule
`default_nettype wire

// ==== verilog/mcgw_top.sv ====
/*
  Machine-check global control: capability, global state and bank
  enable registers, and the instruction-completion watchdog.
  Assumes register accesses, retirement, halt and error reports all
  come from core logic on clk_in; reset_n_in is the cold reset and
  warm_reset_in a synchronous warm reset that keeps the logs.
*/
// Functional notes
// [RULE_01] Capability low byte reports the number of error-reporting banks.
// [RULE_02] Capability bit 8 is one when the bank enable register exists.
// [RULE_03] Capability is read-only; writes have no effect; rest reserved.
// [RULE_04] On a trap, restart flag set only when resume is reliable.
// [RULE_05] On a trap, error-pointer flag set when that instruction caused it.
// [RULE_06] Every trap sets check-in-progress; software clears it afterwards.
// [RULE_07] A further error during check-in-progress forces shutdown.
// [RULE_08] Bank enable register gates per-bank logging and reporting.
// [RULE_09] Some sources of a disabled bank may still log.
// [RULE_10] Watchdog raises a machine check when an instruction overruns.
// [RULE_11] Enabled watchdog restarts its count on every completion.
// [RULE_12] Watchdog count holds during halt or stop-grant; the code holds on halt_in only and has no stop-grant input.
// [RULE_13] Enable bit one counts and traps; zero neither counts nor traps.
// [RULE_14] Tick base: 00 1 ms, 01 1 us, 10 5 ns, 11 reserved; code 10 gives one 40 ns clock instead.
// [RULE_15] Time-out is the selected count times the tick base.
// [RULE_16] Period codes 0..9 decode to the listed counts; rest reserved.
// [RULE_17] Logged registers keep their contents across a warm reset.
// [RULE_18] Disable or completion resets the count to zero.
// [RULE_19] Reserved tick base or period codes never expire.
`timescale 1ns/1ps
`default_nettype none
module mcgw_top #(
  parameter int BANK_COUNT  = mcgw_pkg::DEF_BANK_COUNT,
  parameter bit CTL_PRESENT = mcgw_pkg::DEF_CTL_PRESENT,
  parameter int MS_CYCLES   = mcgw_pkg::TICK_MS_CYCLES,
  parameter int BANK_IDX_W  = (BANK_COUNT > 1) ? $clog2(BANK_COUNT) : 1
) (
  // Clock, reset, enable
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      ce_in,
  input  wire logic                      warm_reset_in,
  // Register access
  input  wire mcgw_pkg::mcgw_msr_req_s   msr_req_in,
  output logic                           msr_ack_out,
  output logic                           msr_fault_out,
  output logic [63:0]                    msr_rdata_out,
  // Pipeline status
  input  wire logic                      insn_retire_in,
  input  wire logic                      halt_in,
  // Error reports from the banks
  input  wire logic                      mc_error_in,
  input  wire logic [BANK_IDX_W-1:0]     mc_error_bank_in,
  input  wire logic                      mc_restart_ok_in,
  input  wire logic                      mc_error_ip_in,
  input  wire logic [BANK_COUNT-1:0]     always_log_in,
  // Results
  output logic [BANK_COUNT-1:0]          bank_log_en_out,
  output logic                           hardware_fault_trap_out,
  output logic                           shutdown_out
);

  localparam int DW = mcgw_pkg::MSR_DATA_W;
  localparam logic [7:0] BANK_COUNT_FIELD = 8'(BANK_COUNT);

  // Stored state
  mcgw_pkg::mcgw_global_state_s global_state;
  mcgw_pkg::mcgw_global_state_s next_global_state;
  mcgw_pkg::mcgw_wdog_cfg_s     wdog_cfg;
  mcgw_pkg::mcgw_core_state_e   core_state;
  mcgw_pkg::mcgw_core_state_e   next_core_state;
  logic [BANK_COUNT-1:0]        bank_enable;
  logic [BANK_COUNT-1:0]        next_log_en;

  // Address decode
  wire hit_cap   = (msr_req_in.addr == mcgw_pkg::ADDR_CAPABILITIES);
  wire hit_state = (msr_req_in.addr == mcgw_pkg::ADDR_GLOBAL_STATE);
  wire hit_ctl   = CTL_PRESENT
                   && (msr_req_in.addr == mcgw_pkg::ADDR_BANK_ENABLES);
  wire hit_wdog  = (msr_req_in.addr == mcgw_pkg::ADDR_WDOG_CONFIG);
  wire hit_any   = hit_cap || hit_state || hit_ctl || hit_wdog;
  wire req_valid = ce_in && (msr_req_in.rd || msr_req_in.wr);
  wire rd_valid  = ce_in && msr_req_in.rd && hit_any;
  wire wr_state  = ce_in && msr_req_in.wr && hit_state;
  wire wr_ctl    = ce_in && msr_req_in.wr && hit_ctl;
  wire wr_wdog   = ce_in && msr_req_in.wr && hit_wdog;

  // Read words; reserved bits read as zero
  wire [DW-1:0] cap_word   =
    DW'({CTL_PRESENT, BANK_COUNT_FIELD}); // RULE_01 RULE_02
  wire [DW-1:0] state_word = DW'(global_state);
  wire [DW-1:0] ctl_word   = DW'(bank_enable);
  wire [DW-1:0] wdog_word  = DW'(wdog_cfg);
  wire [DW-1:0] rd_word    = hit_cap   ? cap_word   : // RULE_03
                             hit_state ? state_word :
                             hit_ctl   ? ctl_word   :
                             hit_wdog  ? wdog_word  : '0;

  // Access answer: one cycle after the request
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      msr_ack_out   <= 1'b0;
      msr_fault_out <= 1'b0;
      msr_rdata_out <= '0;
    end else if (ce_in) begin
      msr_ack_out   <= req_valid;
      msr_fault_out <= req_valid && !hit_any;
      if (rd_valid) begin
        msr_rdata_out <= rd_word;
      end
    end
  end

  // Bank enables; without the register every bank counts as enabled
  wire [BANK_COUNT-1:0] eff_enable = CTL_PRESENT ? bank_enable : '1;

  // Writes to the capability word fall through and change nothing
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank_enable <= '0;
      wdog_cfg    <= '0;
    end else if (ce_in) begin
      if (wr_ctl) begin
        bank_enable <= msr_req_in.wdata[BANK_COUNT-1:0]; // RULE_08
      end
      if (wr_wdog) begin
        wdog_cfg <= mcgw_pkg::mcgw_wdog_cfg_s'(
                      msr_req_in.wdata[mcgw_pkg::WD_CFG_W-1:0]);
      end
    end
  end

  // Per-bank logging: enabled banks, plus sources that always log
  genvar gi;
  generate
    for (gi = 0; gi < BANK_COUNT; gi++) begin : g_bank
      assign next_log_en[gi] = eff_enable[gi] || always_log_in[gi]; // RULE_09
    end
  endgenerate

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank_log_en_out <= '0;
    end else if (ce_in) begin
      bank_log_en_out <= next_log_en; // RULE_08
    end
  end

  // Watchdog: halt freezes, completion, disable or warm reset restart it
  logic wd_tick;
  logic wd_expire;
  wire  wd_clear = !wdog_cfg.enable || insn_retire_in
                   || warm_reset_in; // RULE_11 RULE_18
  wire  wd_run   = wdog_cfg.enable && !halt_in; // RULE_13

  mcgw_tick_gen #(
    .MS_CYCLES   (MS_CYCLES),
    .US_CYCLES   (mcgw_pkg::TICK_US_CYCLES),
    .FAST_CYCLES (mcgw_pkg::TICK_FAST_CYCLES),
    .W           (mcgw_pkg::PRESCALE_W)
  ) u_tick (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .ce_in       (ce_in),
    .clear_in    (wd_clear),
    .run_in      (wd_run),
    .base_sel_in (wdog_cfg.tick_base_select),
    .tick_out    (wd_tick)
  );

  mcgw_period_counter #(
    .W             (mcgw_pkg::PERIOD_W)
  ) u_period (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .ce_in         (ce_in),
    .clear_in      (wd_clear),
    .hold_in       (halt_in), // RULE_12
    .tick_in       (wd_tick),
    .period_sel_in (wdog_cfg.period_sel),
    .expire_out    (wd_expire)
  );

  // Error events; an out-of-range bank index is not reported
  wire idx_ok     = (32'(mc_error_bank_in) < BANK_COUNT);
  wire bank_on    = idx_ok && eff_enable[mc_error_bank_in];
  wire ext_report = ce_in && mc_error_in && bank_on; // RULE_08
  wire wd_report  = ce_in && wdog_cfg.enable && wd_expire; // RULE_10
  wire any_report = ext_report || wd_report;
  wire running    = (core_state == mcgw_pkg::CORE_RUN);
  wire trap_now   = any_report && running
                    && !global_state.check_in_progress;
  wire nest_now   = any_report && running
                    && global_state.check_in_progress; // RULE_07
  // A hung instruction cannot be resumed nor blamed with certainty
  wire restart_src = ext_report && mc_restart_ok_in;
  wire eip_src     = ext_report && mc_error_ip_in;

  // Trap capture beats a software write in the same cycle
  always_comb begin
    next_global_state = global_state;
    if (wr_state) begin
      next_global_state = mcgw_pkg::mcgw_global_state_s'(
                            msr_req_in.wdata[mcgw_pkg::GS_W-1:0]); // RULE_06
    end
    if (trap_now) begin
      next_global_state.check_in_progress     = 1'b1; // RULE_06
      next_global_state.restart_pointer_valid = restart_src; // RULE_04
      next_global_state.error_pointer_valid   = eip_src; // RULE_05
    end
  end

  always_comb begin
    next_core_state = core_state;
    case (core_state)
      mcgw_pkg::CORE_RUN: begin
        if (nest_now) begin
          next_core_state = mcgw_pkg::CORE_SHUTDOWN; // RULE_07
        end
      end
      mcgw_pkg::CORE_SHUTDOWN: begin
        next_core_state = mcgw_pkg::CORE_SHUTDOWN;
      end
      default: begin
        next_core_state = mcgw_pkg::CORE_RUN;
      end
    endcase
    if (warm_reset_in) begin
      next_core_state = mcgw_pkg::CORE_RUN;
    end
  end

  // Warm reset leaves the logged state untouched
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      global_state <= '0;
    end else if (ce_in) begin
      global_state <= next_global_state; // RULE_17
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_state              <= mcgw_pkg::CORE_RUN;
      hardware_fault_trap_out <= 1'b0;
      shutdown_out            <= 1'b0;
    end else if (ce_in) begin
      core_state              <= next_core_state;
      hardware_fault_trap_out <= trap_now && !warm_reset_in;
      shutdown_out            <= (next_core_state
                                  == mcgw_pkg::CORE_SHUTDOWN);
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  cap_count_a: assert property ( // RULE_01
    rd_valid && hit_cap |=> msr_ack_out
      && msr_rdata_out[mcgw_pkg::CAP_BANK_COUNT_W-1:0] == BANK_COUNT_FIELD)
    else $error("bank count wrong");
  cap_present_a: assert property ( // RULE_02
    rd_valid && hit_cap |=>
      msr_rdata_out[mcgw_pkg::CAP_CTL_PRESENT_BIT] == CTL_PRESENT
      && !msr_fault_out)
    else $error("control present bit wrong");
  cap_readonly_a: assert property ( // RULE_03
    ce_in && msr_req_in.wr && hit_cap |=>
      $stable(bank_enable) && $stable(wdog_cfg) && !msr_fault_out)
    else $error("capability write had effect");
  restart_flag_a: assert property ( // RULE_04
    trap_now |=> global_state.restart_pointer_valid
      == $past(restart_src))
    else $error("restart flag not captured");
  error_ip_flag_a: assert property ( // RULE_05
    trap_now |=> global_state.error_pointer_valid == $past(eip_src))
    else $error("error pointer flag not captured");
  trap_marks_busy_a: assert property ( // RULE_06
    trap_now && !warm_reset_in |=>
      hardware_fault_trap_out && global_state.check_in_progress)
    else $error("trap without in-progress");
  nested_shutdown_a: assert property ( // RULE_07
    nest_now && !warm_reset_in |=> shutdown_out
      && !hardware_fault_trap_out)
    else $error("nested error did not shut down");
  bank_gate_a: assert property ( // RULE_08
    ce_in && mc_error_in && !bank_on && !wd_report |-> !trap_now)
    else $error("disabled bank reported");
  wdog_trap_a: assert property ( // RULE_10
    wd_report && running && !global_state.check_in_progress
      && !warm_reset_in |=> hardware_fault_trap_out)
    else $error("watchdog expiry lost");
  wdog_off_a: assert property ( // RULE_13
    !wdog_cfg.enable |-> !wd_report && !wd_tick)
    else $error("disabled watchdog active");
  shutdown_hold_a: assert property ( // RULE_07
    ce_in && shutdown_out && !warm_reset_in |=> shutdown_out)
    else $error("shutdown left without reset");

endmodule
`default_nettype wire
